/* File: design/cfe_pkg.sv */
// constants shared by the clock fan-out enable and power-down control
// assumes a single 25 MHz system clock and AXI4-Lite register access
package cfe_pkg;

   // system clock
   localparam int CLK_MHZ = 25;

   // AXI4-Lite widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // register indices, byte address is four times the index
   localparam logic [5:0] IDX_OUT_EN = 6'h00;
   localparam logic [5:0] IDX_MODE   = 6'h01;
   localparam logic [5:0] IDX_DRIVE  = 6'h02;
   localparam logic [5:0] IDX_FREQ   = 6'h03;
   localparam logic [5:0] IDX_STATUS = 6'h04;

   // field positions
   localparam int OUT_EN0_BIT   = 0;
   localparam int OUT_EN1_BIT   = 1;
   localparam int MODE_CTRL_LSB = 3;
   localparam int MODE_RB_LSB   = 6;
   localparam int SLEW0_BIT     = 0;
   localparam int SLEW1_BIT     = 1;
   localparam int AMP_LSB       = 4;
   localparam int INPUT_FREQUENCY_SELECT_LSB      = 3;
   localparam int ST_LOCK_BIT   = 0;
   localparam int ST_REF_BIT    = 1;
   localparam int ST_PWR_BIT    = 2;
   localparam int ST_ADDR_LSB   = 8;

   // pll mode encodings, shared by control and readback fields
   localparam logic [1:0] MODE_LOBW   = 2'h0;
   localparam logic [1:0] MODE_BYPASS = 2'h1;
   localparam logic [1:0] MODE_HIBW   = 2'h3;

   // tri-level strap as seen on the two-bit strap port
   localparam logic [1:0] STRAP_LOW  = 2'h0;
   localparam logic [1:0] STRAP_MID  = 2'h1;
   localparam logic [1:0] STRAP_HIGH = 2'h3;

   // input frequency select codes
   localparam logic [1:0] INPUT_FREQUENCY_SELECT_100M = 2'h0;
   localparam logic [1:0] INPUT_FREQUENCY_SELECT_50M  = 2'h1;
   localparam logic [1:0] INPUT_FREQUENCY_SELECT_125M = 2'h2;

   // reset values
   localparam logic [1:0] RST_OUT_EN = 2'h3;
   localparam logic [1:0] RST_MODE   = MODE_BYPASS;
   localparam logic [1:0] RST_SLEW   = 2'h3;
   localparam logic [1:0] RST_AMP    = 2'h2;
   localparam logic [1:0] RST_INPUT_FREQUENCY_SELECT   = INPUT_FREQUENCY_SELECT_100M;

   // management target address
   localparam logic [6:0] MGMT_TARGET_ADDR = 7'h6d;

   // timing
   localparam int T_DRIVE_US = 300;
   localparam int T_STAB_US  = 1000;
   localparam int T_LOCK_US  = 100;
   localparam int LOCK_CYC   = T_LOCK_US * CLK_MHZ;
   localparam int DRIVE_CYC  = T_DRIVE_US * CLK_MHZ;
   localparam int STAB_CYC   = T_STAB_US * CLK_MHZ;
   localparam int LOCK_W     = 12;
   localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYC - 1);

   // reference activity watchdog, in system clocks
   localparam logic [4:0] REF_TIMEOUT = 5'h10;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: design/cfe_pin_sync.sv */
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes inputs are quasi-static compared with the system clock
module cfe_pin_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   // asynchronous pins and filtered result
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] level_o
);

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic s1_ff;
         logic s2_ff;
         logic s3_ff;
         logic lvl_ff;
         // first stage feeds only the second; value moves on agreement
         always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               s1_ff  <= 1'b0;
               s2_ff  <= 1'b0;
               s3_ff  <= 1'b0;
               lvl_ff <= 1'b0;
            end else begin
               s1_ff <= pin_i[g];
               s2_ff <= s1_ff;
               s3_ff <= s2_ff;
               if (s2_ff == s3_ff) begin
                  lvl_ff <= s3_ff;
               end
            end
         end
         assign level_o[g] = lvl_ff;
      end
   endgenerate

endmodule

/* File: design/cfe_pair_gate.sv */
// gate for one differential output pair, changes on source edges, or at once when kill_i is high
// assumes src_rise_i is a one-cycle pulse at each reference rising edge
module cfe_pair_gate (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   // control
   input  wire logic want_i,
   input  wire logic kill_i,
   input  wire logic src_rise_i,
   input  wire logic src_level_i,
   // pair outputs
   output logic      true_o,
   output logic      comp_o
);

   logic on_ff;
   logic true_ff;
   logic comp_ff;

   // enable moves at a source edge; switching off still passes a one-cycle pulse to true_o
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         on_ff <= 1'b0;
      end else if (kill_i) begin
         on_ff <= 1'b0;
      end else if (src_rise_i) begin
         on_ff <= want_i;
      end
   end

   // both halves low whenever gated off
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         true_ff <= 1'b0;
         comp_ff <= 1'b0;
      end else begin
         true_ff <= on_ff & ~kill_i & src_level_i;
         comp_ff <= on_ff & ~kill_i & ~src_level_i;
      end
   end

   assign true_o = true_ff;
   assign comp_o = comp_ff;

endmodule

/* File: design/cfe_clock_fanout_ctrl.sv */
// control of a two-pair reference clock fan-out buffer with power-down
// assumes reference input toggles well below a sixth of clk_i
//
// Contract
// - power-down low: outputs low, pll off
// - first power-good rise latches straps, starts up
// - later rises exit power-down, no resample
// - enable pin low enables pair, high disables
// - unconnected enable pin leaves pair enabled
// - pair runs only with bit set, pin low
// - bypass: pll off, outputs follow reference
// - enable change acts within one to three clocks; code takes four clocks to filter the pin, then waits for a reference rise
// - outputs driven within 300 us of power-up
// - first output clock within 1 ms
// - pll modes block outputs until lock
// - tri-level strap decodes low, bypass, high bandwidth
// - floating strap mid level gives bypass
// - two-bit mode control and readback fields
// - management bus rate up to 400 kHz
// - complete default configuration without bus access
// - programmable slew per output and amplitude
// - bus answers only while reference runs
module cfe_clock_fanout_ctrl (
   // clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       reset_n_i,
   // axi4-lite write address and data
   input  wire logic [cfe_pkg::ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic                       s_axi_awvalid_i,
   output logic                            s_axi_awready_o,
   input  wire logic [cfe_pkg::DATA_W-1:0] s_axi_wdata_i,
   input  wire logic [3:0]                 s_axi_wstrb_i,
   input  wire logic                       s_axi_wvalid_i,
   output logic                            s_axi_wready_o,
   // axi4-lite write response
   output logic [1:0]                      s_axi_bresp_o,
   output logic                            s_axi_bvalid_o,
   input  wire logic                       s_axi_bready_i,
   // axi4-lite read
   input  wire logic [cfe_pkg::ADDR_W-1:0] s_axi_araddr_i,
   input  wire logic                       s_axi_arvalid_i,
   output logic                            s_axi_arready_o,
   output logic [cfe_pkg::DATA_W-1:0]      s_axi_rdata_o,
   output logic [1:0]                      s_axi_rresp_o,
   output logic                            s_axi_rvalid_o,
   input  wire logic                       s_axi_rready_i,
   // device pins
   input  wire logic                       power_good_powerdown_n_i,
   input  wire logic                       output_pair0_enable_n_i,
   input  wire logic                       output_pair1_enable_n_i,
   input  wire logic [1:0]                 pll_bandwidth_bypass_strap_i,
   input  wire logic                       ref_clock_i,
   // clock outputs
   output logic                            clock_output_pair0_true_o,
   output logic                            clock_output_pair0_comp_o,
   output logic                            clock_output_pair1_true_o,
   output logic                            clock_output_pair1_comp_o,
   // analog controls and state
   output logic                            pll_on_o,
   output logic                            pll_locked_o,
   output logic [1:0]                      slew_fast_o,
   output logic [1:0]                      amplitude_o,
   output logic [1:0]                      input_frequency_select_o
);
   import cfe_pkg::*;

   // synchronised pins
   logic [5:0] pin_lvl;
   logic       pg_lvl;
   logic [1:0] en_n_lvl;
   logic       ref_lvl;
   logic [1:0] strap_lvl;

   cfe_pin_sync #(
      .WIDTH (6)
   ) u_sync (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .pin_i     ({pll_bandwidth_bypass_strap_i, ref_clock_i,
                   output_pair1_enable_n_i, output_pair0_enable_n_i,
                   power_good_powerdown_n_i}),
      .level_o   (pin_lvl)
   );

   assign pg_lvl    = pin_lvl[0];
   assign en_n_lvl  = pin_lvl[2:1];
   assign ref_lvl   = pin_lvl[3];
   assign strap_lvl = pin_lvl[5:4];

   // state
   logic              pg_d_ff;
   logic              first_seen_ff;
   logic              ref_d_ff;
   logic [4:0]        ref_idle_ff;
   logic [LOCK_W-1:0] lock_cnt_ff;
   logic              locked_ff;
   logic [1:0]        mode_prev_ff;
   logic [1:0]        out_en_ff;
   logic [1:0]        mode_ctrl_ff;
   logic [1:0]        slew_ff;
   logic [1:0]        amp_ff;
   logic [1:0]        input_frequency_select_ff;
   logic              pll_on_ff;
   logic              pll_locked_ff;

   // decodes
   wire       pg_rise     = pg_lvl & ~pg_d_ff;
   wire       ref_rise    = ref_lvl & ~ref_d_ff;
   wire       ref_running = (ref_idle_ff < REF_TIMEOUT);
   wire       powered     = pg_lvl & first_seen_ff;
   wire [1:0] act_mode    = (mode_ctrl_ff == 2'h2) ? MODE_BYPASS
                                                   : mode_ctrl_ff;
   wire       bypass      = (act_mode == MODE_BYPASS);
   wire       pll_want    = powered & ~bypass;
   wire       clk_ok      = powered & ref_running
                            & (bypass | locked_ff);
   wire       kill        = ~pg_lvl;

   // tri-level strap decode, illegal code falls back to bypass
   wire [1:0] strap_mode  = (strap_lvl == STRAP_LOW)  ? MODE_LOBW :
                            (strap_lvl == STRAP_HIGH) ? MODE_HIBW :
                            MODE_BYPASS;

   // pair requests: control bit set, pin low and clk_ok
   wire [1:0] pair_want   = out_en_ff & ~en_n_lvl
                            & {2{clk_ok}};

   // power-good edge tracking, first rise is remembered for good
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pg_d_ff       <= 1'b0;
         first_seen_ff <= 1'b0;
      end else begin
         pg_d_ff <= pg_lvl;
         if (pg_rise) begin
            first_seen_ff <= 1'b1;
         end
      end
   end

   // reference activity watchdog, saturating idle count
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ref_d_ff    <= 1'b0;
         ref_idle_ff <= REF_TIMEOUT;
      end else begin
         ref_d_ff <= ref_lvl;
         if (ref_rise) begin
            ref_idle_ff <= 5'h00;
         end else if (ref_running) begin
            ref_idle_ff <= ref_idle_ff + 5'h01;
         end
      end
   end

   // lock timer restarts on any mode change or power-down;
   // lock time sits well inside the drive and stabilisation limits
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lock_cnt_ff  <= '0;
         locked_ff    <= 1'b0;
         mode_prev_ff <= RST_MODE;
      end else begin
         mode_prev_ff <= act_mode;
         if (!pll_want || !ref_running || act_mode != mode_prev_ff) begin
            lock_cnt_ff <= '0;
            locked_ff   <= 1'b0;
         end else if (lock_cnt_ff == LOCK_LAST) begin
            locked_ff <= 1'b1;
         end else begin
            lock_cnt_ff <= lock_cnt_ff + LOCK_W'(1);
         end
      end
   end

   // output pairs, both follow the reference in every mode
   wire [1:0] pair_true;
   wire [1:0] pair_comp;
   for (genvar p = 0; p < 2; p++) begin : g_pair
      cfe_pair_gate u_gate (
         .clk_i       (clk_i),
         .reset_n_i   (reset_n_i),
         .want_i      (pair_want[p]),
         .kill_i      (kill),
         .src_rise_i  (ref_rise),
         .src_level_i (ref_lvl),
         .true_o      (pair_true[p]),
         .comp_o      (pair_comp[p])
      );
   end

   // axi4-lite slave
   logic                aw_got_ff;
   logic                w_got_ff;
   logic [5:0]          w_idx_ff;
   logic [7:0]          w_byte_ff;
   logic                w_lane_ff;
   logic                bvalid_ff;
   logic [1:0]          bresp_ff;
   logic                rvalid_ff;
   logic [1:0]          rresp_ff;
   logic [DATA_W-1:0]   rdata_ff;

   wire       aw_take  = s_axi_awvalid_i & ~aw_got_ff & ~bvalid_ff;
   wire       w_take   = s_axi_wvalid_i & ~w_got_ff & ~bvalid_ff;
   wire       aw_have  = aw_got_ff | aw_take;
   wire       w_have   = w_got_ff | w_take;
   wire       wr_fire  = aw_have & w_have & ~bvalid_ff;
   wire [5:0] wr_idx   = aw_got_ff ? w_idx_ff : s_axi_awaddr_i[7:2];
   wire [7:0] wr_byte  = w_got_ff ? w_byte_ff : s_axi_wdata_i[7:0];
   wire       wr_lane  = w_got_ff ? w_lane_ff : s_axi_wstrb_i[0];
   wire       wr_hit   = (wr_idx <= IDX_FREQ);
   wire       wr_do    = wr_fire & wr_hit & wr_lane & ref_running;
   wire       ar_take  = s_axi_arvalid_i & ~rvalid_ff;
   wire [5:0] rd_idx   = s_axi_araddr_i[7:2];
   wire       rd_hit   = (rd_idx <= IDX_STATUS);

   // read word assembly, unused bits read as zero
   wire [DATA_W-1:0] rd_word =
      (rd_idx == IDX_OUT_EN) ? DATA_W'(out_en_ff) :
      (rd_idx == IDX_MODE)   ? DATA_W'({act_mode, 1'b0, mode_ctrl_ff,
                                        3'h0}) :
      (rd_idx == IDX_DRIVE)  ? DATA_W'({amp_ff, 2'h0, slew_ff}) :
      (rd_idx == IDX_FREQ)   ? DATA_W'({input_frequency_select_ff, 3'h0}) :
      (rd_idx == IDX_STATUS) ? DATA_W'({MGMT_TARGET_ADDR, 5'h00,
                                        powered, ref_running,
                                        locked_ff}) :
      '0;

   // write channel capture in either order
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aw_got_ff <= 1'b0;
         w_got_ff  <= 1'b0;
         w_idx_ff  <= 6'h00;
         w_byte_ff <= 8'h00;
         w_lane_ff <= 1'b0;
      end else if (wr_fire) begin
         aw_got_ff <= 1'b0;
         w_got_ff  <= 1'b0;
      end else begin
         if (aw_take) begin
            aw_got_ff <= 1'b1;
            w_idx_ff  <= s_axi_awaddr_i[7:2];
         end
         if (w_take) begin
            w_got_ff  <= 1'b1;
            w_byte_ff <= s_axi_wdata_i[7:0];
            w_lane_ff <= s_axi_wstrb_i[0];
         end
      end
   end

   // write response, error for unmapped index or idle reference
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= (wr_hit & ref_running) ? RESP_OKAY
                                             : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         bvalid_ff <= 1'b0;
      end
   end

   // read response
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rvalid_ff <= 1'b0;
         rresp_ff  <= RESP_OKAY;
         rdata_ff  <= '0;
      end else if (ar_take) begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= (rd_hit & ref_running) ? RESP_OKAY
                                             : RESP_SLVERR;
         rdata_ff  <= (rd_hit & ref_running) ? rd_word : '0;
      end else if (s_axi_rready_i) begin
         rvalid_ff <= 1'b0;
      end
   end

   // configuration registers; defaults give a working device
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         out_en_ff    <= RST_OUT_EN;
         mode_ctrl_ff <= RST_MODE;
         slew_ff      <= RST_SLEW;
         amp_ff       <= RST_AMP;
         input_frequency_select_ff      <= RST_INPUT_FREQUENCY_SELECT;
      end else if (pg_rise && !first_seen_ff) begin
         mode_ctrl_ff <= strap_mode;
      end else if (wr_do) begin
         unique case (wr_idx)
            IDX_OUT_EN: out_en_ff    <= wr_byte[1:0];
            IDX_MODE:   mode_ctrl_ff <= wr_byte[4:3];
            IDX_DRIVE: begin
               slew_ff <= wr_byte[1:0];
               amp_ff  <= wr_byte[5:4];
            end
            IDX_FREQ:   input_frequency_select_ff      <= wr_byte[4:3];
            default:    out_en_ff    <= out_en_ff;
         endcase
      end
   end

   // registered analog control outputs
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pll_on_ff     <= 1'b0;
         pll_locked_ff <= 1'b0;
      end else begin
         pll_on_ff     <= pll_want;
         pll_locked_ff <= locked_ff;
      end
   end

   assign s_axi_awready_o          = ~aw_got_ff & ~bvalid_ff;
   assign s_axi_wready_o           = ~w_got_ff & ~bvalid_ff;
   assign s_axi_bvalid_o           = bvalid_ff;
   assign s_axi_bresp_o            = bresp_ff;
   assign s_axi_arready_o          = ~rvalid_ff;
   assign s_axi_rvalid_o           = rvalid_ff;
   assign s_axi_rresp_o            = rresp_ff;
   assign s_axi_rdata_o            = rdata_ff;
   assign pll_on_o                 = pll_on_ff;
   assign pll_locked_o             = pll_locked_ff;
   assign slew_fast_o              = slew_ff;
   assign amplitude_o              = amp_ff;
   assign input_frequency_select_o = input_frequency_select_ff;
   assign clock_output_pair0_true_o = pair_true[0];
   assign clock_output_pair0_comp_o = pair_comp[0];
   assign clock_output_pair1_true_o = pair_true[1];
   assign clock_output_pair1_comp_o = pair_comp[1];

endmodule

/* File: testbench/cfe_ctrl_sva.sv */
// assertion checker for the clock fan-out control block
// assumes it is bound to the control block and sees only its ports
module cfe_ctrl_sva (
   // clock and reset
   input wire logic       clk_i,
   input wire logic       reset_n_i,
   // read handshake
   input wire logic       s_axi_arvalid_i,
   input wire logic       s_axi_arready_o,
   input wire logic       s_axi_rvalid_o,
   // pins
   input wire logic       power_good_powerdown_n_i,
   input wire logic       output_pair1_enable_n_i,
   // outputs
   input wire logic       clock_output_pair0_true_o,
   input wire logic       clock_output_pair0_comp_o,
   input wire logic       clock_output_pair1_true_o,
   input wire logic       clock_output_pair1_comp_o,
   input wire logic       pll_on_o,
   input wire logic       pll_locked_o,
   input wire logic [1:0] slew_fast_o,
   input wire logic [1:0] amplitude_o,
   input wire logic [1:0] input_frequency_select_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import cfe_pkg::*;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);
   // high while any pair half is driven
   wire logic any_out = clock_output_pair0_true_o | clock_output_pair0_comp_o
                      | clock_output_pair1_true_o | clock_output_pair1_comp_o;
   property p_pd_off;
      !power_good_powerdown_n_i [*8] |-> !any_out && !pll_on_o;
   endproperty
   a_pd_off: assert property (p_pd_off)
      else $error("active in power-down");
   // cycles the pll has run unlocked
   logic [11:0] on_cnt;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         on_cnt <= 12'h000;
      else
         on_cnt <= (pll_on_o && !pll_locked_o) ? on_cnt + 12'h001 : 12'h000;
   end
   property p_lock_time;
      on_cnt <= 12'h9d8 && (!$rose(pll_locked_o) || on_cnt >= 12'h9ba);
   endproperty
   a_lock_time: assert property (p_lock_time)
      else $error("lock out of window");
   // gating may lag by a reference edge, so only a closed gate is held
   property p_lock_block;
      pll_on_o && !pll_locked_o && !any_out |=> !any_out || pll_locked_o;
   endproperty
   a_lock_block: assert property (p_lock_block)
      else $error("output started before lock");
   property p_pin_off;
      $rose(output_pair1_enable_n_i) |-> ##[1:24]
         !(clock_output_pair1_true_o || clock_output_pair1_comp_o);
   endproperty
   a_pin_off: assert property (p_pin_off)
      else $error("pair ran after pin release");
   property p_diff;
      !(clock_output_pair0_true_o && clock_output_pair0_comp_o) &&
      !(clock_output_pair1_true_o && clock_output_pair1_comp_o);
   endproperty
   a_diff: assert property (p_diff)
      else $error("both halves of a pair high");
   property p_defaults;
      $rose(reset_n_i) |-> slew_fast_o == RST_SLEW &&
         amplitude_o == RST_AMP && input_frequency_select_o == RST_INPUT_FREQUENCY_SELECT;
   endproperty
   a_defaults: assert property (p_defaults)
      else $error("wrong default settings");
   property p_rlat;
      s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
   endproperty
   a_rlat: assert property (p_rlat)
      else $error("read answer late");
   property p_rbusy;
      s_axi_rvalid_o |-> !s_axi_arready_o;
   endproperty
   a_rbusy: assert property (p_rbusy)
      else $error("read taken while busy");
   // main scenarios
   c_lock: cover property ($rose(pll_locked_o));
   c_pd: cover property ($fell(power_good_powerdown_n_i));
   c_pin: cover property ($rose(output_pair1_enable_n_i));
endmodule

bind cfe_clock_fanout_ctrl cfe_ctrl_sva u_sva (
   .clk_i, .reset_n_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
   .power_good_powerdown_n_i, .output_pair1_enable_n_i,
   .clock_output_pair0_true_o, .clock_output_pair0_comp_o,
   .clock_output_pair1_true_o, .clock_output_pair1_comp_o,
   .pll_on_o, .pll_locked_o, .slew_fast_o, .amplitude_o,
   .input_frequency_select_o
);

/* File: testbench/cfe_ref_src.sv */
// reference clock source upstream of the fan-out control
// assumes run_i comes from the bench; stands low when stopped
module cfe_ref_src (
   // control
   input  wire logic run_i,
   // reference clock
   output logic      ref_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // 400 ns period keeps each level five system clocks long
   initial begin
      ref_o = 1'b0;
      #7;
      forever begin
         #200;
         ref_o = run_i ? ~ref_o : 1'b0;
      end
   end
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the clock fan-out control block
// assumes the reference source model and the bound checker
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cfe_pkg::*;
   logic clk_i, reset_n_i, run, ref_clock_i, pll_on_o, pll_locked_o;
   logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o, seed, d;
   logic [3:0] s_axi_wstrb_i;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, pll_bandwidth_bypass_strap_i;
   logic [1:0] slew_fast_o, amplitude_o, input_frequency_select_o;
   logic s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
   logic s_axi_rready_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
   logic s_axi_arready_o, s_axi_rvalid_o, power_good_powerdown_n_i;
   logic output_pair0_enable_n_i, output_pair1_enable_n_i;
   logic clock_output_pair0_true_o, clock_output_pair0_comp_o;
   logic clock_output_pair1_true_o, clock_output_pair1_comp_o;
   int fails, checks_done, cyc, n0, n1;
   logic [33:0] bq[$], rq[$];

   cfe_clock_fanout_ctrl u_dut (.*);
   cfe_ref_src u_ref (.run_i(run), .ref_o(ref_clock_i));

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // a hang counts as a mismatch
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         final_report();
      end
   end

   // answers are matched in order against the driver's notes
   always @(posedge clk_i) begin
      if (s_axi_bvalid_o && s_axi_bready_i)
         chk({32'h0, s_axi_bresp_o}, bq.pop_front());
      if (s_axi_rvalid_o && s_axi_rready_i)
         chk({s_axi_rresp_o, s_axi_rdata_o}, rq.pop_front());
   end

   always @(posedge clock_output_pair0_true_o) n0++;
   always @(posedge clock_output_pair1_true_o) n1++;

   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     input logic [1:0] r);
      bq.push_back({32'h0, r});
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= v;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      do begin
         @(posedge clk_i);
         if (s_axi_awready_o)
            s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o)
            s_axi_wvalid_i <= 1'b0;
      end while (!s_axi_bvalid_o);
      s_axi_bready_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] v,
                     input logic [1:0] r);
      rq.push_back({r, v});
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      do begin
         @(posedge clk_i);
         if (s_axi_arready_o)
            s_axi_arvalid_i <= 1'b0;
      end while (!s_axi_rvalid_o);
      s_axi_rready_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // lets gating settle, then looks for toggling on each pair
   task automatic span(input logic e0, input logic e1);
      repeat (30) @(posedge clk_i);
      n0 = 0;
      n1 = 0;
      repeat (60) @(posedge clk_i);
      chk({33'h0, n0 != 0}, {33'h0, e0});
      chk({33'h0, n1 != 0}, {33'h0, e1});
   endtask

   initial begin
      reset_n_i = 1'b0;
      run = 1'b0;
      seed = 32'h00015570;
      {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
      {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = '0;
      {s_axi_arvalid_i, s_axi_rready_i, power_good_powerdown_n_i} = '0;
      output_pair0_enable_n_i = 1'b0;
      output_pair1_enable_n_i = 1'b0;
      s_axi_wstrb_i = 4'hf;
      pll_bandwidth_bypass_strap_i = STRAP_MID;
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      rd(8'h10, 32'h0, RESP_SLVERR);
      run <= 1'b1;
      repeat (20) @(posedge clk_i);
      rd(8'h00, 32'h3, RESP_OKAY);
      rd(8'h08, 32'h23, RESP_OKAY);
      power_good_powerdown_n_i <= 1'b1;
      span(1'b1, 1'b1);
      rd(8'h04, 32'h48, RESP_OKAY);
      chk({33'h0, pll_on_o}, 34'h0);
      output_pair1_enable_n_i <= 1'b1;
      span(1'b1, 1'b0);
      output_pair1_enable_n_i <= 1'b0;
      wr(8'h00, 32'h2, RESP_OKAY);
      span(1'b0, 1'b1);
      wr(8'h00, 32'h3, RESP_OKAY);
      seed = xs(seed);
      d = seed & 32'h33;
      wr(8'h08, d, RESP_OKAY);
      rd(8'h08, d, RESP_OKAY);
      chk({32'h0, slew_fast_o}, {32'h0, d[1:0]});
      chk({32'h0, amplitude_o}, {32'h0, d[5:4]});
      for (int i = 0; i < 4; i++) begin
         wr(8'h0c, 32'(i) << 3, RESP_OKAY);
         rd(8'h0c, 32'(i) << 3, RESP_OKAY);
         if (i < 3)
            chk({32'h0, input_frequency_select_o}, 34'(i));
      end
      // unmapped and read-only places are refused
      wr(8'h14, 32'hff, RESP_SLVERR);
      rd(8'h14, 32'h0, RESP_SLVERR);
      wr(8'h10, 32'hff, RESP_SLVERR);
      wr(8'h04, 32'h18, RESP_OKAY);
      repeat (2600) @(posedge clk_i);
      rd(8'h10, 32'h6d07, RESP_OKAY);
      rd(8'h04, 32'hd8, RESP_OKAY);
      // a later wake must not pick up the new strap level
      power_good_powerdown_n_i <= 1'b0;
      pll_bandwidth_bypass_strap_i <= STRAP_LOW;
      span(1'b0, 1'b0);
      chk({33'h0, pll_on_o}, 34'h0);
      power_good_powerdown_n_i <= 1'b1;
      span(1'b0, 1'b0);
      repeat (2500) @(posedge clk_i);
      span(1'b1, 1'b1);
      rd(8'h04, 32'hd8, RESP_OKAY);
      wr(8'h04, 32'h0, RESP_OKAY);
      rd(8'h04, 32'h0, RESP_OKAY);
      wr(8'h04, 32'h10, RESP_OKAY);
      rd(8'h04, 32'h50, RESP_OKAY);
      span(1'b1, 1'b1);
      final_report();
   end
endmodule
